// ===== common/ebw_pkg.sv
// constants, field layout and carrier types of the external bus wait-state interface
// assumes a single machine clock; one external cycle per machine-cycle step
package ebw_pkg;

    localparam logic [15:0] CFG_PORT_ADDR = 16'hFFFC;
    localparam logic [11:0] CFG_RESET = 12'hFFF;
    localparam logic [3:0] CFG_RSVD_READ = 4'h0;
    localparam int CFG_FIELD_W = 3;
    localparam int LOWER_PROG_LSB = 0;
    localparam int UPPER_PROG_LSB = 3;
    localparam int DATA_WAIT_LSB = 6;
    localparam int IO_WAIT_LSB = 9;
    localparam int UPPER_HALF_BIT = 15;
    localparam logic [2:0] NO_WAITS = 3'h0;
    localparam logic [7:0] GMAP_NONE = 8'h00;

    typedef enum logic [1:0] {
        SP_PROG = 2'b00,
        SP_DATA = 2'b01,
        SP_IO = 2'b10
    } ebw_space_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACCESS = 2'b10
    } ebw_state_t;

    typedef enum logic [1:0] {
        KIND_WR = 2'b00,
        KIND_RD = 2'b01,
        KIND_PF = 2'b10
    } ebw_kind_t;

    // one internal bus request, held by the core until its done pulse
    typedef struct packed {
        logic valid;
        ebw_space_t space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ebw_req_t;

    // external pins; all strobes and selects active low
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] dout;
        logic doe;
        logic rw;
        logic access_strobe_n;
        logic rd_n;
        logic we_n;
        logic ps_n;
        logic ds_n;
        logic is_n;
        logic br_n;
    } ebw_pins_t;

    localparam ebw_pins_t PINS_IDLE = '{
        addr: 16'h0000, dout: 16'h0000, doe: 1'b0, rw: 1'b1, access_strobe_n: 1'b1,
        rd_n: 1'b1, we_n: 1'b1, ps_n: 1'b1, ds_n: 1'b1, is_n: 1'b1, br_n: 1'b1
    };

endpackage

// ===== design/ebw_iface.sv
// external parallel bus interface with programmable wait-state generator
// assumes requests are synchronous to ref_clk_in and held until their done pulse
`timescale 1ns/1ns

module ebw_iface (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire ebw_pkg::ebw_req_t wr_req_in,
    input wire ebw_pkg::ebw_req_t rd_req_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic fetch_valid_in,
    input wire logic [7:0] global_map_size_in,
    input wire logic ready_in,
    input wire logic [15:0] data_in,
    output ebw_pkg::ebw_pins_t bus_out,
    output logic wr_done_out,
    output logic rd_done_out,
    output logic fetch_done_out,
    output logic [15:0] rdata_out
);

    typedef struct packed {
        ebw_pkg::ebw_state_t st;
        logic [2:0] cnt;
        ebw_pkg::ebw_kind_t kind;
        logic [11:0] cfg;
        ebw_pkg::ebw_pins_t pins;
        logic done_wr;
        logic done_rd;
        logic done_pf;
        logic [15:0] rdata;
    } ebw_regs_t;

    localparam ebw_regs_t REGS_RESET = '{
        st: ebw_pkg::ST_IDLE, cnt: ebw_pkg::NO_WAITS, kind: ebw_pkg::KIND_WR,
        cfg: ebw_pkg::CFG_RESET, pins: ebw_pkg::PINS_IDLE, done_wr: 1'b0,
        done_rd: 1'b0, done_pf: 1'b0, rdata: 16'h0000
    };

    logic [1:0] rst_sync;
    logic rst_n;
    ebw_regs_t r;
    ebw_regs_t next_r;

    // decode of the 3-bit wait field for the addressed space
    function automatic logic [2:0] wait_count(input ebw_pkg::ebw_space_t sp,
                                              input logic [15:0] a,
                                              input logic [11:0] cfg);
        logic [2:0] w;
        w = ebw_pkg::NO_WAITS;
        unique case (sp)
            ebw_pkg::SP_PROG: begin
                if (a[ebw_pkg::UPPER_HALF_BIT]) begin
                    w = cfg[ebw_pkg::UPPER_PROG_LSB +: ebw_pkg::CFG_FIELD_W];
                end else begin
                    w = cfg[ebw_pkg::LOWER_PROG_LSB +: ebw_pkg::CFG_FIELD_W];
                end
            end
            ebw_pkg::SP_DATA: w = cfg[ebw_pkg::DATA_WAIT_LSB +: ebw_pkg::CFG_FIELD_W];
            ebw_pkg::SP_IO: w = cfg[ebw_pkg::IO_WAIT_LSB +: ebw_pkg::CFG_FIELD_W];
            default: w = cfg[ebw_pkg::IO_WAIT_LSB +: ebw_pkg::CFG_FIELD_W];
        endcase
        return w;
    endfunction

    // global region lies only in the upper half; map size gives its lower bound
    function automatic logic is_global(input logic [15:0] a, input logic [7:0] gmap);
        return a[ebw_pkg::UPPER_HALF_BIT] && gmap[7] && (a[15:8] >= gmap)
            && (gmap != ebw_pkg::GMAP_NONE);
    endfunction

    function automatic logic is_cfg_port(input ebw_pkg::ebw_req_t q);
        return (q.space == ebw_pkg::SP_IO) && (q.addr == ebw_pkg::CFG_PORT_ADDR);
    endfunction

    // the reset copy drops asynchronously, so an external write is cut off at once
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    logic wr_ok;
    logic rd_ok;
    logic pf_ok;
    logic sel_any;
    logic sel_wr;
    ebw_pkg::ebw_kind_t sel_kind;
    ebw_pkg::ebw_req_t sel_req;

    always_comb begin
        next_r = r;
        next_r.done_wr = 1'b0;
        next_r.done_rd = 1'b0;
        next_r.done_pf = 1'b0;
        // a request whose done is showing is not taken again this cycle
        wr_ok = wr_req_in.valid && !r.done_wr;
        rd_ok = rd_req_in.valid && !r.done_rd;
        pf_ok = fetch_valid_in && !r.done_pf;
        sel_any = wr_ok || rd_ok || pf_ok;
        sel_req = '{valid: pf_ok, space: ebw_pkg::SP_PROG, addr: fetch_addr_in,
                    wdata: 16'h0000};
        sel_kind = ebw_pkg::KIND_PF;
        if (wr_ok) begin
            sel_req = wr_req_in;
            sel_kind = ebw_pkg::KIND_WR;
        end else if (rd_ok) begin
            sel_req = rd_req_in;
            sel_kind = ebw_pkg::KIND_RD;
        end
        sel_wr = (sel_kind == ebw_pkg::KIND_WR);
        unique case (r.st)
            ebw_pkg::ST_IDLE: begin
                next_r.pins.access_strobe_n = 1'b1;
                next_r.pins.rd_n = 1'b1;
                next_r.pins.we_n = 1'b1;
                next_r.pins.ps_n = 1'b1;
                next_r.pins.ds_n = 1'b1;
                next_r.pins.is_n = 1'b1;
                next_r.pins.br_n = 1'b1;
                next_r.pins.doe = 1'b0;
                next_r.pins.rw = 1'b1;
                if (sel_any && is_cfg_port(sel_req)) begin
                    // on-chip port: served internally, no external cycle
                    if (sel_wr) begin
                        next_r.cfg = sel_req.wdata[11:0];
                        next_r.done_wr = 1'b1;
                    end else begin
                        next_r.rdata = {ebw_pkg::CFG_RSVD_READ, r.cfg};
                        next_r.done_rd = (sel_kind == ebw_pkg::KIND_RD);
                        next_r.done_pf = (sel_kind == ebw_pkg::KIND_PF);
                    end
                end else if (sel_any) begin
                    next_r.kind = sel_kind;
                    next_r.cnt = wait_count(sel_req.space, sel_req.addr, r.cfg);
                    next_r.pins.addr = sel_req.addr;
                    next_r.pins.rw = !sel_wr;
                    next_r.pins.access_strobe_n = 1'b0;
                    next_r.pins.ps_n = (sel_req.space != ebw_pkg::SP_PROG);
                    next_r.pins.ds_n = (sel_req.space != ebw_pkg::SP_DATA);
                    next_r.pins.is_n = (sel_req.space != ebw_pkg::SP_IO);
                    next_r.pins.br_n = !((sel_kind != ebw_pkg::KIND_PF)
                        && (sel_req.space == ebw_pkg::SP_DATA)
                        && is_global(sel_req.addr, global_map_size_in));
                    if (sel_wr) begin
                        // extra setup cycle turns the data bus around before write enable
                        next_r.st = ebw_pkg::ST_SETUP;
                        next_r.pins.dout = sel_req.wdata;
                        next_r.pins.doe = 1'b1;
                    end else begin
                        next_r.st = ebw_pkg::ST_ACCESS;
                        next_r.pins.rd_n = 1'b0;
                    end
                end
            end
            ebw_pkg::ST_SETUP: begin
                next_r.st = ebw_pkg::ST_ACCESS;
                next_r.pins.we_n = 1'b0;
            end
            ebw_pkg::ST_ACCESS: begin
                if (r.cnt != ebw_pkg::NO_WAITS) begin
                    next_r.cnt = r.cnt - 3'h1;
                end else if (ready_in) begin
                    next_r.st = ebw_pkg::ST_IDLE;
                    next_r.pins.access_strobe_n = 1'b1;
                    next_r.pins.rd_n = 1'b1;
                    next_r.pins.we_n = 1'b1;
                    next_r.pins.ps_n = 1'b1;
                    next_r.pins.ds_n = 1'b1;
                    next_r.pins.is_n = 1'b1;
                    next_r.pins.br_n = 1'b1;
                    next_r.pins.doe = 1'b0;
                    next_r.pins.rw = 1'b1;
                    next_r.done_wr = (r.kind == ebw_pkg::KIND_WR);
                    next_r.done_rd = (r.kind == ebw_pkg::KIND_RD);
                    next_r.done_pf = (r.kind == ebw_pkg::KIND_PF);
                    if (r.kind != ebw_pkg::KIND_WR) begin
                        next_r.rdata = data_in;
                    end
                end
            end
            default: next_r = REGS_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign bus_out = r.pins;
    assign wr_done_out = r.done_wr;
    assign rd_done_out = r.done_rd;
    assign fetch_done_out = r.done_pf;
    assign rdata_out = r.rdata;

    a_read_direction: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !r.pins.rd_n |-> (r.pins.rw && !r.pins.access_strobe_n))
        else $error("read strobe without read direction or access strobe");

    a_strobe_every: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (r.st != ebw_pkg::ST_IDLE) |-> !r.pins.access_strobe_n)
        else $error("external cycle without access strobe");

    a_write_strobe_only: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !r.pins.we_n |-> (!r.pins.rw && r.pins.rd_n && r.pins.doe))
        else $error("write enable outside a write cycle");

    a_ready_holds: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (r.st == ebw_pkg::ST_ACCESS && r.cnt == ebw_pkg::NO_WAITS && !ready_in)
        |=> (r.st == ebw_pkg::ST_ACCESS && !r.done_wr && !r.done_rd && !r.done_pf))
        else $error("access ended without ready");

    a_global_request: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !r.pins.br_n |-> (!r.pins.ds_n && r.pins.addr[ebw_pkg::UPPER_HALF_BIT]))
        else $error("global request outside upper data space");

    a_zero_wait_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (r.st == ebw_pkg::ST_ACCESS && r.kind == ebw_pkg::KIND_RD
         && r.cnt == ebw_pkg::NO_WAITS && ready_in)
        |=> (r.done_rd && r.st == ebw_pkg::ST_IDLE))
        else $error("ready read did not complete");

    a_write_two_cycles: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        $fell(r.pins.we_n) |-> ($past(r.st) == ebw_pkg::ST_SETUP && $past(!r.pins.access_strobe_n)))
        else $error("write enable without setup cycle");

    a_programmed_waits: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (r.st == ebw_pkg::ST_ACCESS && r.cnt != ebw_pkg::NO_WAITS)
        |=> (r.st == ebw_pkg::ST_ACCESS && r.cnt == $past(r.cnt) - 3'h1))
        else $error("programmed wait cut short");

    a_cfg_read_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (r.st == ebw_pkg::ST_IDLE && !wr_req_in.valid && rd_req_in.valid && !r.done_rd
         && is_cfg_port(rd_req_in))
        |=> (r.done_rd && r.rdata[15:12] == ebw_pkg::CFG_RSVD_READ
             && r.rdata[11:0] == $past(r.cfg)))
        else $error("configuration read wrong");

    a_write_first: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (r.st == ebw_pkg::ST_IDLE && wr_req_in.valid && !r.done_wr && !is_cfg_port(wr_req_in))
        |=> (r.kind == ebw_pkg::KIND_WR && r.st == ebw_pkg::ST_SETUP))
        else $error("write not served first");

    a_select_one: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !r.pins.access_strobe_n |-> $onehot({!r.pins.ps_n, !r.pins.ds_n, !r.pins.is_n}))
        else $error("external cycle without exactly one space select");

    a_global_no_fetch: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !r.pins.br_n |-> (r.kind != ebw_pkg::KIND_PF && r.st != ebw_pkg::ST_IDLE))
        else $error("global request outside a data access");

endmodule

// ===== sim/ebw_ext_mem.sv
// external memory and I/O model facing the bus pins of the wait-state interface
// assumes one machine clock; hold_in stretches ready like a slow or arbitrating device
`timescale 1ns/1ns

module ebw_ext_mem (
    input wire logic clk_in,
    input wire ebw_pkg::ebw_pins_t bus_in,
    input wire logic hold_in,
    output logic ready_out,
    output logic [15:0] data_out
);
    logic [15:0] mem [16];
    logic [15:0] last;

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'hA500 + 16'(i);
        end
        last = 16'h0000;
    end

    // ready withheld while arbitrating or slow, for as long as the bench wants
    assign ready_out = !hold_in;
    // released bus never repeats its last value, so stale reads show
    assign data_out = !bus_in.rd_n ? mem[bus_in.addr[3:0]] : ~last;

    always @(posedge clk_in) begin
        last <= data_out;
        if (!bus_in.we_n) begin
            mem[bus_in.addr[3:0]] <= bus_in.dout;
        end
    end
endmodule

// ===== sim/ebw_iface_bench.sv
// self-checking bench for the external bus wait-state interface
// assumes the memory model answers every space from one small array
`timescale 1ns/1ns

module ebw_iface_bench;
    logic clk, rst_n, fv, hold, rdy, wd, rdn, fd, br_seen;
    logic [15:0] fa, din, rdata;
    logic [7:0] gmap;
    ebw_pkg::ebw_req_t wr, rd;
    ebw_pkg::ebw_pins_t bus;
    int error_cnt = 0, checked = 0, cyc = 0, n;

    ebw_iface uut (.ref_clk_in(clk), .rst_n_in(rst_n), .wr_req_in(wr), .rd_req_in(rd),
        .fetch_addr_in(fa), .fetch_valid_in(fv), .global_map_size_in(gmap),
        .ready_in(rdy), .data_in(din), .bus_out(bus), .wr_done_out(wd),
        .rd_done_out(rdn), .fetch_done_out(fd), .rdata_out(rdata));
    ebw_ext_mem mem (.clk_in(clk), .bus_in(bus), .hold_in(hold), .ready_out(rdy),
        .data_out(din));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // kind 0 write, 1 read, 2 fetch; n counts falling edges until done
    task automatic xfer(input int kind, input logic [1:0] sp, input logic [15:0] a,
        input logic [15:0] v, output int cnt);
        logic d;
        @(posedge clk);
        if (kind == 0) wr <= '{1'b1, ebw_pkg::ebw_space_t'(sp), a, v};
        else if (kind == 1) rd <= '{1'b1, ebw_pkg::ebw_space_t'(sp), a, v};
        else begin
            fa <= a;
            fv <= 1'b1;
        end
        cnt = 0;
        d = 1'b0;
        while (d !== 1'b1 && cnt < 300) begin
            @(negedge clk);
            cnt++;
            d = (kind == 0) ? wd : (kind == 1) ? rdn : fd;
        end
        @(posedge clk);
        wr.valid <= 1'b0;
        rd.valid <= 1'b0;
        fv <= 1'b0;
    endtask

    task automatic set_cfg(input logic [15:0] v);
        xfer(0, 2'b10, 16'hFFFC, v, n);
    endtask

    // direction and strobes must agree on every bus cycle
    always @(negedge clk) begin
        if (!bus.rd_n || !bus.we_n) check({14'h0, bus.rw, bus.access_strobe_n}, {14'h0, !bus.rd_n, 1'b0});
        if (!bus.access_strobe_n) check(16'($countones({bus.ps_n, bus.ds_n, bus.is_n})), 16'h0002);
        if (!bus.br_n) br_seen = 1'b1;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic t_reset_cfg();
        check(16'(bus), 16'(ebw_pkg::PINS_IDLE));
        xfer(1, 2'b10, 16'hFFFC, 16'h0000, n);
        check(rdata, 16'h0FFF);
        check(16'(n), 16'h0002);
        xfer(1, 2'b01, 16'h0003, 16'h0000, n);
        check(16'(n), 16'h000A);
        check(rdata, 16'hA503);
        $display("test reset_cfg done");
    endtask

    task automatic t_fields();
        int kd [6] = '{2, 2, 1, 1, 0, 0};
        logic [1:0] sp [6] = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b01, 2'b00};
        logic [15:0] ad [6] = '{16'h0005, 16'h8006, 16'h0007, 16'h0009, 16'h000A, 16'h8004};
        int w [6] = '{1, 2, 3, 4, 3, 2};
        set_cfg(16'hF8D1);
        xfer(1, 2'b10, 16'hFFFC, 16'h0000, n);
        check(rdata, 16'h08D1);
        for (int i = 0; i < 6; i++) begin
            xfer(kd[i], sp[i], ad[i], 16'h5A5A, n);
            check(16'(n), 16'(w[i] + (kd[i] == 0 ? 4 : 3)));
        end
        xfer(1, 2'b01, 16'h000A, 16'h0000, n);
        check(rdata, 16'h5A5A);
        $display("test fields done");
    endtask

    task automatic t_zero();
        set_cfg(16'h0000);
        xfer(1, 2'b01, 16'h0002, 16'h0000, n);
        check(16'(n), 16'h0003);
        xfer(0, 2'b01, 16'h0002, 16'h1234, n);
        check(16'(n), 16'h0004);
        $display("test zero done");
    endtask

    task automatic t_ready();
        @(posedge clk);
        hold <= 1'b1;
        fork
            xfer(1, 2'b01, 16'h0002, 16'h0000, n);
            begin
                repeat (20) @(posedge clk);
                hold <= 1'b0;
            end
        join
        check(16'(n), 16'h0015);
        check(rdata, 16'h1234);
        $display("test ready done");
    endtask

    task automatic t_global();
        gmap <= 8'h80;
        br_seen = 1'b0;
        xfer(1, 2'b01, 16'h9000, 16'h0000, n);
        check({15'h0, br_seen}, 16'h0001);
        br_seen = 1'b0;
        xfer(1, 2'b01, 16'h1000, 16'h0000, n);
        xfer(2, 2'b00, 16'h9000, 16'h0000, n);
        check({15'h0, br_seen}, 16'h0000);
        $display("test global done");
    endtask

    task automatic t_order();
        logic [5:0] ord;
        logic w, r, f;
        int k;
        ord = 6'h00;
        k = 0;
        @(posedge clk);
        wr <= '{1'b1, ebw_pkg::SP_DATA, 16'h0001, 16'h1111};
        rd <= '{1'b1, ebw_pkg::SP_DATA, 16'h0002, 16'h0000};
        fa <= 16'h0003;
        fv <= 1'b1;
        for (int i = 0; i < 80 && k < 3; i++) begin
            @(negedge clk);
            w = (wd === 1'b1);
            r = (rdn === 1'b1);
            f = (fd === 1'b1);
            if (w || r || f) begin
                ord = {ord[3:0], f, r};
                k++;
            end
            @(posedge clk);
            wr.valid <= wr.valid & ~w;
            rd.valid <= rd.valid & ~r;
            fv <= fv & ~f;
        end
        check({10'h0, ord}, 16'h0006);
        $display("test order done");
    endtask

    task automatic t_abort();
        set_cfg(16'h01C0);
        @(posedge clk);
        wr <= '{1'b1, ebw_pkg::SP_DATA, 16'h000C, 16'hBEEF};
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        wr.valid <= 1'b0;
        #1;
        check({14'h0, bus.we_n, bus.access_strobe_n}, 16'h0003);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(1, 2'b10, 16'hFFFC, 16'h0000, n);
        check(rdata, 16'h0FFF);
        $display("test abort done");
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        fv = 1'b0;
        hold = 1'b0;
        fa = 16'h0000;
        gmap = 8'h00;
        br_seen = 1'b0;
        wr = '0;
        rd = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_cfg();
        t_fields();
        t_zero();
        t_ready();
        t_global();
        t_order();
        t_abort();
        report_and_stop();
    end
endmodule
